// *** pkg/btt_pkg.sv ***
// Purpose: Shared constants and types for the bus transfer termination ends.
// Assumes: One bus clock of 200 MHz; all termination signals active low.
// Notes:   Pin functions select routing of the multiplexed pins.
package btt_pkg;
   localparam int unsigned IRQ_COUNT      = 8;
   localparam int unsigned IRQ_LINE_THREE = 3;
   localparam int unsigned IRQ_LINE_FOUR  = 4;
   localparam int unsigned TIMEOUT_W      = 16;
   localparam logic [TIMEOUT_W-1:0] TIMEOUT_RESET = 16'h00FF;
   localparam int unsigned SPK_DIV_W      = 12;
   localparam logic [SPK_DIV_W-1:0] SPK_DIV_RESET = 12'h100;
   localparam logic ACT_LOW_ON  = 1'b0;
   localparam logic ACT_LOW_OFF = 1'b1;

   // Who terminates the current transaction.
   typedef enum logic [1:0] {
      BTT_OWN_EXTERNAL = 2'h0,
      BTT_OWN_CARDSLOT = 2'h1,
      BTT_OWN_MEMCTL   = 2'h2,
      BTT_OWN_GENERAL_CHIP_SELECT_MACHINE_EXT = 2'h3
   } btt_owner_type;

   // Function of the shared kill/retry/interrupt/speaker pin.
   typedef enum logic [1:0] {
      BTT_KPIN_KILL  = 2'h0,
      BTT_KPIN_RETRY = 2'h1,
      BTT_KPIN_IRQ   = 2'h2,
      BTT_KPIN_SPKR  = 2'h3
   } btt_kpin_type;

   // Master cycle states, one bit changing from idle to wait to done; done back to idle changes two.
   typedef enum logic [2:0] {
      BTT_IDLE  = 3'h0,
      BTT_WAIT  = 3'h1,
      BTT_DONE  = 3'h3,
      BTT_RETRY = 3'h2,
      BTT_ERROR = 3'h6
   } btt_state_type;
endpackage

// *** pkg/btt_bus_if.sv ***
// Purpose: Pin-level termination bus between the processor end and a slave end.
// Assumes: Open-drain and bidirectional pins resolve with pull-ups to one.
// Notes:   Each driver gives output and enable; the wire level is worked out here.
`timescale 1ns/100ps
interface btt_bus_if;
   logic devTaOut, devTaOe, slvTaOut, slvTaOe;
   logic devTeaOut, devTeaOe;
   logic devBiOut, devBiOe, slvBiOut, slvBiOe;
   logic slvRetryOut, slvRetryOe, devKpinOut, devKpinOe;
   logic slvKillOut, slvKillOe;
   logic transferStart_n, reservationOut, reservationOe;
   logic transferAck_n, transferErrorAck_n, noBurstFlag_n, kpinLevel;

   assign transferAck_n      = !((devTaOe && !devTaOut) || (slvTaOe && !slvTaOut));
   assign transferErrorAck_n = !(devTeaOe && !devTeaOut);
   assign noBurstFlag_n      = !((devBiOe && !devBiOut) || (slvBiOe && !slvBiOut));
   assign kpinLevel = devKpinOe ? devKpinOut :
                      !((slvRetryOe && !slvRetryOut) || (slvKillOe && !slvKillOut));

   modport device (
      output devTaOut, devTaOe, devTeaOut, devTeaOe, devBiOut, devBiOe,
      output devKpinOut, devKpinOe, transferStart_n, reservationOut, reservationOe,
      input  transferAck_n, transferErrorAck_n, noBurstFlag_n, kpinLevel
   );
   modport slave (
      output slvTaOut, slvTaOe, slvBiOut, slvBiOe, slvRetryOut, slvRetryOe,
      output slvKillOut, slvKillOe,
      input  transferStart_n, reservationOut, transferErrorAck_n, transferAck_n
   );
endinterface

// *** src/btt_master_end.sv ***
// Purpose: Processor end of the bus termination handshake and interrupt merge.
// Assumes: Inputs synchronous to clk; one transfer outstanding at a time.
// Notes:   Timeout counter is loaded at each start; a timeout ends the cycle in error.
`timescale 1ns/100ps
//////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// - Addressed slave acknowledges accepted or valid data.
// - Device drives acknowledge for cardslot or memctl.
// - Chip-select external mode waits for slave acknowledge.
// - Slave negates and releases acknowledge after cycle.
// - Bus monitor timeout asserts transfer error.
// - Error ends cycle, acknowledge ignored then.
// - Non-burst slave asserts burst inhibit on bursts.
// - Device drives burst inhibit for cardslot or memctl.
// - Reservation output accompanies reserve-type transfer addresses.
// - Kill input sampled during store-conditional transfers.
// - Busy slave asserts retry.
// - Retry drops mastership, rearbitrate then restart.
// - Eight external interrupt requests reach controller.
// - Line four is AND of configured pins.
// - Line three is AND of cancel and parity zero.
// - Cancel input invalidates current reservation.
// - Retry pin alternate function outputs speaker wave.
module btt_master_end
   import btt_pkg::*;
(
   // Clock and reset
   input  wire logic                          clk,
   input  wire logic                          arst_n,
   input  wire logic                          clkEn,
   // Bus pins
   btt_bus_if.device                          bus,
   // Core request side
   input  wire logic                          startReq,
   input  wire logic                          reserveType,
   input  wire logic                          storeCond,
   input  wire logic                          burstReq,
   input  wire btt_pkg::btt_owner_type        owner,
   input  wire logic                          internalAckDue,
   input  wire logic                          internalNoBurst,
   input  wire logic                          busGrant,
   input  wire logic [btt_pkg::TIMEOUT_W-1:0] timeoutCycles,
   output logic                               cycleDone,
   output logic                               cycleError,
   output logic                               cycleRetry,
   output logic                               busRequest,
   output logic                               noBurstSeen,
   output logic                               reservationValid,
   output logic                               storeCondFailed,
   // Pin configuration and interrupts
   input  wire btt_pkg::btt_kpin_type         kpinMode,
   input  wire logic                          parity0IsIrq,
   input  wire logic                          parity1IsIrq,
   input  wire logic                          cancelIsIrq,
   input  wire logic                          parityLineZero,
   input  wire logic                          parityLineOne,
   input  wire logic                          cancelResvIn_n,
   input  wire logic [btt_pkg::IRQ_COUNT-1:0] interruptPins_n,
   input  wire logic [btt_pkg::SPK_DIV_W-1:0] speakerHalfPeriod,
   input  wire logic                          speakerEnable,
   output logic [btt_pkg::IRQ_COUNT-1:0]      interruptReq
);
   import btt_pkg::*;

   if (TIMEOUT_W < 2 || IRQ_COUNT != 8) begin
      $error("btt_master_end: unsupported width");
   end

   btt_state_type                 state_q;
   logic [TIMEOUT_W-1:0]          timer_q;
   logic [SPK_DIV_W-1:0]          spkCnt_q;
   logic                          spkWave_q;
   logic                          storeCond_q;
   logic                          reserveType_q;
   logic                          ownAck;
   logic                          ackSeen;
   logic                          retrySeen;
   logic                          killSeen;
   logic                          startNow;

   function automatic logic pinAsserted(input logic level_n);
      return level_n == ACT_LOW_ON;
   endfunction

   //////////////////////////////////////////////////////////////////////////
   // Termination decode.
   assign ownAck    = (owner == BTT_OWN_CARDSLOT) || (owner == BTT_OWN_MEMCTL);
   // A chip-select cycle set for external acknowledge never drives it.
   assign ackSeen   = pinAsserted(bus.transferAck_n);
   assign retrySeen = (kpinMode == BTT_KPIN_RETRY) && pinAsserted(bus.kpinLevel);
   assign killSeen  = (kpinMode == BTT_KPIN_KILL) && pinAsserted(bus.kpinLevel);
   assign startNow  = (state_q == BTT_IDLE) && startReq && busGrant;

   //////////////////////////////////////////////////////////////////////////
   // Cycle state machine and bus monitor.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         state_q       <= BTT_IDLE;
         timer_q       <= '0;
         storeCond_q   <= 1'b0;
         reserveType_q <= 1'b0;
      end else if (clkEn) begin
         case (state_q)
            BTT_IDLE: begin
               if (startNow) begin
                  state_q       <= BTT_WAIT;
                  timer_q       <= timeoutCycles;
                  storeCond_q   <= storeCond;
                  reserveType_q <= reserveType;
               end
            end
            BTT_WAIT: begin
               if (timer_q == '0) begin
                  state_q <= BTT_ERROR;
               end else if (retrySeen) begin
                  state_q <= BTT_RETRY;
               end else if (ackSeen || (ownAck && internalAckDue)) begin
                  state_q <= BTT_DONE;
               end else begin
                  timer_q <= timer_q - 1'b1;
               end
            end
            BTT_DONE, BTT_ERROR, BTT_RETRY: begin
               state_q <= BTT_IDLE;
            end
            default: begin
               state_q <= BTT_IDLE;
            end
         endcase
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // Pin drivers; the error cycle ignores any acknowledge level.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         bus.devTaOut        <= ACT_LOW_OFF;
         bus.devTaOe         <= 1'b0;
         bus.devTeaOut       <= ACT_LOW_OFF;
         bus.devTeaOe        <= 1'b0;
         bus.devBiOut        <= ACT_LOW_OFF;
         bus.devBiOe         <= 1'b0;
         bus.transferStart_n <= ACT_LOW_OFF;
         bus.reservationOut  <= ACT_LOW_OFF;
         bus.reservationOe   <= 1'b0;
      end else if (clkEn) begin
         bus.transferStart_n <= startNow ? ACT_LOW_ON : ACT_LOW_OFF;
         bus.reservationOut  <= startNow && reserveType ? ACT_LOW_ON : ACT_LOW_OFF;
         bus.reservationOe   <= startNow;
         bus.devTaOe  <= (state_q == BTT_WAIT) && ownAck && internalAckDue;
         bus.devTaOut <= !((state_q == BTT_WAIT) && ownAck && internalAckDue);
         bus.devBiOe  <= (state_q == BTT_WAIT) && ownAck;
         bus.devBiOut <= !((state_q == BTT_WAIT) && ownAck && internalNoBurst && burstReq);
         bus.devTeaOe  <= (state_q == BTT_WAIT) && (timer_q == '0);
         bus.devTeaOut <= !((state_q == BTT_WAIT) && (timer_q == '0));
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // Status back to the core.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         cycleDone   <= 1'b0;
         cycleError  <= 1'b0;
         cycleRetry  <= 1'b0;
         busRequest  <= 1'b0;
         noBurstSeen <= 1'b0;
      end else if (clkEn) begin
         cycleError <= (state_q == BTT_WAIT) && (timer_q == '0);
         cycleDone  <= (state_q == BTT_WAIT) && (timer_q != '0) && !retrySeen
                       && (ackSeen || (ownAck && internalAckDue));
         cycleRetry <= (state_q == BTT_WAIT) && (timer_q != '0) && retrySeen;
         // Mastership is dropped for a retry and requested again.
         busRequest <= startReq && (state_q == BTT_IDLE) && !startNow;
         noBurstSeen <= (state_q == BTT_WAIT) && burstReq
                        && pinAsserted(bus.noBurstFlag_n);
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // Reservation tracking; a new reserve start wins over a cancel in the same cycle.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         reservationValid <= 1'b0;
         storeCondFailed  <= 1'b0;
      end else if (clkEn) begin
         if (startNow && reserveType && !storeCond) begin
            reservationValid <= 1'b1;
         end else if (!cancelIsIrq && pinAsserted(cancelResvIn_n)) begin
            reservationValid <= 1'b0;
         end else if (state_q == BTT_WAIT && storeCond_q) begin
            reservationValid <= 1'b0;
         end
         if (startNow) begin
            storeCondFailed <= 1'b0;
         end else if (state_q == BTT_WAIT && storeCond_q && reserveType_q && killSeen) begin
            storeCondFailed <= 1'b1;
         end
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // Speaker tone on the shared pin, a square wave from a divider.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         spkCnt_q      <= SPK_DIV_RESET;
         spkWave_q     <= 1'b0;
         bus.devKpinOut <= 1'b0;
         bus.devKpinOe  <= 1'b0;
      end else if (clkEn) begin
         if (spkCnt_q == '0) begin
            spkCnt_q  <= speakerHalfPeriod;
            spkWave_q <= !spkWave_q && speakerEnable;
         end else begin
            spkCnt_q <= spkCnt_q - 1'b1;
         end
         bus.devKpinOe  <= (kpinMode == BTT_KPIN_SPKR);
         bus.devKpinOut <= spkWave_q;
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // Interrupt merge; an unconfigured pin counts as asserted in the AND.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         interruptReq <= '0;
      end else if (clkEn) begin
         for (int i = 0; i < IRQ_COUNT; i++) begin
            interruptReq[i] <= pinAsserted(interruptPins_n[i]);
         end
         interruptReq[IRQ_LINE_FOUR] <=
            ((kpinMode == BTT_KPIN_IRQ) || parity1IsIrq)
            && ((kpinMode != BTT_KPIN_IRQ) || pinAsserted(bus.kpinLevel))
            && (!parity1IsIrq || pinAsserted(parityLineOne));
         interruptReq[IRQ_LINE_THREE] <=
            (cancelIsIrq || parity0IsIrq)
            && (!cancelIsIrq || pinAsserted(cancelResvIn_n))
            && (!parity0IsIrq || pinAsserted(parityLineZero));
      end
   end
endmodule

// *** src/btt_slave_end.sv ***
// Purpose: External slave end that terminates transfers on the shared bus.
// Assumes: Inputs synchronous to clk; the user side says how to answer.
// Notes:   Acknowledge is negated one cycle after it is given and released the cycle after that.
`timescale 1ns/100ps
module btt_slave_end
   import btt_pkg::*;
(
   // Clock and reset
   input  wire logic clk,
   input  wire logic arst_n,
   input  wire logic clkEn,
   // Bus pins
   btt_bus_if.slave  bus,
   // User side
   input  wire logic selected,
   input  wire logic canBurst,
   input  wire logic isBurst,
   input  wire logic busy,
   input  wire logic killResv,
   input  wire logic dataReady,
   output logic      transferSeen,
   output logic      ackGiven
);
   import btt_pkg::*;

   logic active_q;
   logic release_q;

   //////////////////////////////////////////////////////////////////////////
   // Track the addressed transfer from start to termination.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         active_q     <= 1'b0;
         transferSeen <= 1'b0;
      end else if (clkEn) begin
         transferSeen <= (bus.transferStart_n == ACT_LOW_ON) && selected;
         if (bus.transferStart_n == ACT_LOW_ON && selected) begin
            active_q <= 1'b1;
         end else if (bus.transferErrorAck_n == ACT_LOW_ON || bus.slvTaOe
                      || bus.slvRetryOe) begin
            active_q <= 1'b0;
         end
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // Pin drivers; acknowledge drives high for one cycle then releases, the others release at once.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         bus.slvTaOut    <= ACT_LOW_OFF;
         bus.slvTaOe     <= 1'b0;
         bus.slvBiOut    <= ACT_LOW_OFF;
         bus.slvBiOe     <= 1'b0;
         bus.slvRetryOut <= ACT_LOW_OFF;
         bus.slvRetryOe  <= 1'b0;
         bus.slvKillOut  <= ACT_LOW_OFF;
         bus.slvKillOe   <= 1'b0;
         release_q       <= 1'b0;
         ackGiven        <= 1'b0;
      end else if (clkEn) begin
         ackGiven <= 1'b0;
         release_q <= 1'b0;
         if (active_q && !bus.slvTaOe && !busy && dataReady && !bus.slvRetryOe) begin
            bus.slvTaOut <= ACT_LOW_ON;
            bus.slvTaOe  <= 1'b1;
            ackGiven     <= 1'b1;
         end else if (bus.slvTaOe && bus.slvTaOut == ACT_LOW_ON) begin
            bus.slvTaOut <= ACT_LOW_OFF;
            release_q    <= 1'b1;
         end else if (release_q) begin
            bus.slvTaOe <= 1'b0;
         end
         bus.slvBiOe  <= active_q && isBurst && !canBurst;
         bus.slvBiOut <= !(active_q && isBurst && !canBurst);
         bus.slvRetryOe  <= active_q && busy && !bus.slvRetryOe;
         bus.slvRetryOut <= !(active_q && busy && !bus.slvRetryOe);
         bus.slvKillOe   <= active_q && killResv;
         bus.slvKillOut  <= !(active_q && killResv);
      end
   end
endmodule

// *** verif/btt_bus_properties.sv ***
// Purpose: Concurrent checks on the termination bus joining both ends.
// Assumes: Bench timeouts stay far below the wait limit.
// Notes:   Sees the interface signals only; instantiated beside the bus.
`timescale 1ns/100ps
module btt_bus_properties (
   // Clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // Drivers of the shared lines
   input wire logic devTaOut,
   input wire logic devTaOe,
   input wire logic slvTaOut,
   input wire logic slvTaOe,
   input wire logic devBiOe,
   input wire logic slvBiOe,
   // Resolved lines and strobes
   input wire logic transferAck_n,
   input wire logic transferErrorAck_n,
   input wire logic transferStart_n,
   input wire logic reservationOe,
   input wire logic kpinLevel
);
   localparam int WAIT_LIMIT = 40;
   logic       inCycle_q;
   logic [7:0] waitCnt_q;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);
   //////////////////////////////////////////////////////////////////////////////
   // A transfer is open from its start strobe to its acknowledge or error.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         inCycle_q <= 1'b0;
      end else if (!transferStart_n) begin
         inCycle_q <= 1'b1;
      end else if (!transferAck_n || !transferErrorAck_n) begin
         inCycle_q <= 1'b0;
      end
   end
   // A retry or kill pulse restarts the count, since the master then waits for the bus.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         waitCnt_q <= 8'h00;
      end else if (!transferStart_n || !kpinLevel || !inCycle_q) begin
         waitCnt_q <= 8'h00;
      end else if (waitCnt_q != 8'hFF) begin
         waitCnt_q <= waitCnt_q + 8'h01;
      end
   end
   //////////////////////////////////////////////////////////////////////////////
   start_one_cycle_a: assert property (!transferStart_n |=> transferStart_n)
      else $error("start strobe held longer than one cycle");
   resv_with_start_a: assert property (reservationOe |-> !transferStart_n)
      else $error("reservation driven outside the start cycle");
   ack_in_cycle_a: assert property (!transferAck_n |-> (inCycle_q || !transferStart_n))
      else $error("acknowledge seen with no open transfer");
   ack_release_a: assert property ((slvTaOe && !slvTaOut) |=> slvTaOut ##[0:1] !slvTaOe)
      else $error("slave acknowledge not negated and released");
   no_contention_a: assert property (!(devTaOe && slvTaOe) && !(devBiOe && slvBiOe))
      else $error("both ends drive a shared line");
   error_pulse_a: assert property (!transferErrorAck_n |=> transferErrorAck_n)
      else $error("error acknowledge longer than one cycle");
   error_drops_ack_a: assert property (
      !transferErrorAck_n |-> inCycle_q && !(devTaOe && !devTaOut))
      else $error("error outside a transfer or with own acknowledge");
   error_ends_cycle_a: assert property (
      !transferErrorAck_n |=> transferStart_n && transferAck_n)
      else $error("activity right after error termination");
   monitor_bound_a: assert property (waitCnt_q < 8'(WAIT_LIMIT))
      else $error("transfer never terminated by the bus monitor");
   ack_seen_c: cover property (!transferAck_n);
   error_seen_c: cover property (!transferErrorAck_n);
   resv_seen_c: cover property (reservationOe);
   kpin_low_c: cover property (!kpinLevel && inCycle_q);
endmodule

// *** verif/tb_top.sv ***
// Purpose: Self-checking bench joining the processor end to a slave end.
// Assumes: Timeouts of 4 to 12 cycles; the slave is deselected for internal owners.
// Notes:   Expected results come from a small model of the termination rules.
`timescale 1ns/100ps
module tb_top;
   import btt_pkg::*;
   logic                 clk, arst_n, startReq, reserveType, storeCond, burstReq, busGrant;
   logic                 internalAckDue, internalNoBurst, cycleDone, cycleError, cycleRetry;
   logic                 busRequest, noBurstSeen, reservationValid, storeCondFailed;
   logic                 parity0IsIrq, parity1IsIrq, cancelIsIrq, parityLineZero, parityLineOne;
   logic                 cancelResvIn_n, speakerEnable, selected, canBurst, busy, killResv;
   logic                 dataReady, transferSeen, ackGiven;
   logic [TIMEOUT_W-1:0] timeoutCycles;
   logic [SPK_DIV_W-1:0] speakerHalfPeriod;
   logic [IRQ_COUNT-1:0] interruptPins_n, interruptReq;
   btt_owner_type        owner;
   btt_kpin_type         kpinMode;
   int                   badCount, checksDone;
   btt_bus_if btt_bus_if_i ();
   btt_master_end btt_master_end_i (
      .clk, .arst_n, .clkEn(1'b1), .bus(btt_bus_if_i), .startReq, .reserveType, .storeCond,
      .burstReq, .owner, .internalAckDue, .internalNoBurst, .busGrant, .timeoutCycles,
      .cycleDone, .cycleError, .cycleRetry, .busRequest, .noBurstSeen, .reservationValid,
      .storeCondFailed, .kpinMode, .parity0IsIrq, .parity1IsIrq, .cancelIsIrq,
      .parityLineZero, .parityLineOne, .cancelResvIn_n, .interruptPins_n,
      .speakerHalfPeriod, .speakerEnable, .interruptReq);
   btt_slave_end btt_slave_end_i (
      .clk, .arst_n, .clkEn(1'b1), .bus(btt_bus_if_i), .selected, .canBurst,
      .isBurst(burstReq), .busy, .killResv, .dataReady, .transferSeen, .ackGiven);
   btt_bus_properties btt_bus_properties_i (
      .clk, .arst_n, .devTaOut(btt_bus_if_i.devTaOut), .devTaOe(btt_bus_if_i.devTaOe),
      .slvTaOut(btt_bus_if_i.slvTaOut), .slvTaOe(btt_bus_if_i.slvTaOe),
      .devBiOe(btt_bus_if_i.devBiOe), .slvBiOe(btt_bus_if_i.slvBiOe),
      .transferAck_n(btt_bus_if_i.transferAck_n),
      .transferErrorAck_n(btt_bus_if_i.transferErrorAck_n),
      .transferStart_n(btt_bus_if_i.transferStart_n),
      .reservationOe(btt_bus_if_i.reservationOe), .kpinLevel(btt_bus_if_i.kpinLevel));
   //////////////////////////////////////////////////////////////////////////////
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   task automatic closeOut();
      $display("comparisons %0d mismatches %0d", checksDone, badCount);
      if (badCount == 0 && checksDone > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
      checksDone++;
      if (got !== exp) begin
         badCount++;
         $display("wrong value %s expected %0h seen %0h", what, exp, got);
      end
   endtask
   // Field order of f: select, ready, busy, burst, reserve, store, kill, can burst, own inhibit.
   task automatic xfer(input btt_owner_type own, input btt_kpin_type mode, input logic [8:0] f);
      int         n, acks, seen;
      logic       inner, expRetry, expDone, nb, expNb;
      logic [1:0] res;
      inner = (own == BTT_OWN_CARDSLOT) || (own == BTT_OWN_MEMCTL);
      {selected, dataReady, busy, burstReq, reserveType, storeCond} = f[8:3];
      {killResv, canBurst, internalNoBurst} = f[2:0];
      owner = own;
      kpinMode = mode;
      internalAckDue = 1'b1;
      expRetry = !inner && selected && busy;
      expDone = inner || (selected && dataReady);
      expNb = burstReq && (inner ? internalNoBurst : selected && !canBurst);
      seen = expRetry ? 4 : (selected ? 2 * dataReady + 1 : 0);
      startReq = 1'b1;
      busGrant = 1'b1;
      @(negedge clk);
      startReq = 1'b0;
      n = 0;
      acks = 0;
      nb = 1'b0;
      res = 2'd0;
      while (res == 2'd0 && n < 100) begin
         @(negedge clk);
         n++;
         startReq = 1'b0;
         nb = nb | noBurstSeen | !btt_bus_if_i.noBurstFlag_n;
         acks += {ackGiven, transferSeen};
         if (cycleRetry === 1'b1) begin
            check("retry pulse", 16'(expRetry), 16'h0001);
            {busGrant, startReq} = 2'b01;
            busy = 1'b0;
            repeat (3) @(negedge clk);
            check("bus request", 16'h0001, 16'(busRequest));
            busGrant = 1'b1;
            expRetry = 1'b0;
         end
         if (cycleDone === 1'b1) res = 2'd1;
         if (cycleError === 1'b1) res = 2'd2;
      end
      check("missed retry", 16'(expRetry), 16'h0000);
      check("termination", expDone ? 16'h0001 : 16'h0002, 16'(res));
      if (!expDone) check("timeout span", 16'h0001, 16'(n - timeoutCycles <= 6));
      check("burst inhibit", 16'(expNb), 16'(nb));
      check("slave strobes", 16'(seen), 16'(acks));
      @(negedge clk);
      check("store failed", 16'(storeCond && killResv && mode == BTT_KPIN_KILL),
            16'(storeCondFailed));
      if (expDone && reserveType && !storeCond)
         check("reservation", 16'h0001, 16'(reservationValid));
   endtask
   // Lines three and four merge two pins; an unconfigured pin does not veto the other.
   task automatic irqCheck();
      logic [7:0] exp;
      logic       a, b;
      exp = ~interruptPins_n;
      a = cancelIsIrq ? !cancelResvIn_n : 1'b1;
      b = parity0IsIrq ? !parityLineZero : 1'b1;
      exp[IRQ_LINE_THREE] = (cancelIsIrq || parity0IsIrq) && a && b;
      a = (kpinMode == BTT_KPIN_IRQ) ? !btt_bus_if_i.kpinLevel : 1'b1;
      b = parity1IsIrq ? !parityLineOne : 1'b1;
      exp[IRQ_LINE_FOUR] = ((kpinMode == BTT_KPIN_IRQ) || parity1IsIrq) && a && b;
      check("interrupt requests", 16'(exp), 16'(interruptReq));
   endtask
   initial begin
      repeat (20000) @(posedge clk);
      badCount++;
      $display("wrong value watchdog expected finish seen hang");
      closeOut();
   end
   //////////////////////////////////////////////////////////////////////////////
   initial begin
      logic [8:0]    f;
      btt_owner_type own;
      btt_kpin_type  mode;
      int            n;
      logic          prev;
      {arst_n, startReq, reserveType, storeCond, burstReq, internalAckDue} = 6'h00;
      {internalNoBurst, busGrant, selected, canBurst, busy, killResv, dataReady} = 7'h00;
      {speakerEnable, parity0IsIrq, parity1IsIrq, cancelIsIrq} = 4'h0;
      {parityLineZero, parityLineOne, cancelResvIn_n} = 3'h7;
      interruptPins_n = 8'hFF;
      timeoutCycles = 16'h0008;
      speakerHalfPeriod = 12'h004;
      owner = BTT_OWN_EXTERNAL;
      kpinMode = BTT_KPIN_KILL;
      badCount = 0;
      checksDone = 0;
      repeat (12) @(negedge clk);
      arst_n = 1'b1;
      void'($urandom(32'hD192));
      @(negedge clk);
      xfer(BTT_OWN_GENERAL_CHIP_SELECT_MACHINE_EXT, BTT_KPIN_KILL, 9'h000);
      xfer(BTT_OWN_EXTERNAL, BTT_KPIN_RETRY, 9'h1C0);
      xfer(BTT_OWN_EXTERNAL, BTT_KPIN_KILL, 9'h19C);
      xfer(BTT_OWN_MEMCTL, BTT_KPIN_KILL, 9'h021);
      xfer(BTT_OWN_EXTERNAL, BTT_KPIN_KILL, 9'h190);
      cancelResvIn_n = 1'b0;
      repeat (2) @(negedge clk);
      cancelResvIn_n = 1'b1;
      repeat (3) @(negedge clk);
      check("cancelled reservation", 16'h0000, 16'(reservationValid));
      for (int k = 0; k < 40; k++) begin
         own = btt_owner_type'($urandom_range(3, 0));
         mode = ($urandom_range(1, 0) == 1) ? BTT_KPIN_RETRY : BTT_KPIN_KILL;
         f = 9'($urandom);
         if (own == BTT_OWN_CARDSLOT || own == BTT_OWN_MEMCTL) f[8] = 1'b0;
         if (mode != BTT_KPIN_RETRY) f[6] = 1'b0;
         else f[2] = 1'b0;
         if (f[6]) f[7] = 1'b1;
         if (!f[8] || !f[7]) f[2] = 1'b0;
         if (f[3]) f[4] = 1'b1;
         timeoutCycles = 16'($urandom_range(12, 4));
         xfer(own, mode, f);
      end
      for (int k = 0; k < 8; k++) begin
         interruptPins_n = 8'($urandom);
         {parity0IsIrq, parity1IsIrq, cancelIsIrq} = 3'($urandom);
         {parityLineZero, parityLineOne, cancelResvIn_n} = 3'($urandom);
         kpinMode = k[0] ? BTT_KPIN_IRQ : BTT_KPIN_KILL;
         repeat (4) @(negedge clk);
         irqCheck();
      end
      kpinMode = BTT_KPIN_SPKR;
      speakerEnable = 1'b1;
      repeat (8) @(negedge clk);
      n = 0;
      prev = btt_bus_if_i.devKpinOut;
      repeat (40) begin
         @(negedge clk);
         if (btt_bus_if_i.devKpinOut !== prev) n++;
         prev = btt_bus_if_i.devKpinOut;
      end
      check("speaker wave", 16'h0001,
            16'(n >= 7 && n <= 11 && btt_bus_if_i.devKpinOe));
      closeOut();
   end
endmodule
